/* File: sim_ctl.sv */
// counter, exception control and low-power control of the integration block
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "sim_ctl_regs.svh"
// Summary of operation
// - 12-bit counter advances on each crystal clock falling-edge enable
// - each counter overflow is a one-cycle watchdog tick
// - counter held cleared in stop, then times stop recovery
// - recovery length sampled at wake: 32 cycles if short select, else 4096
// - pin reset leaves counter alone; counter free-runs after reset
// - hardware interrupt taken at instruction boundary if unmasked and enabled
// - request latched with constant vector; nothing pre-empts in run until serviced or a cli executes; wait and stop wakes ignore the latch
// - highest priority pending request chosen at a boundary
// - request pending on return is taken before next program instruction
// - entry stacks registers and sets mask; return restores them
// - high index register is not stacked on entry
// - software interrupt ignores mask and stacks current program counter
// - any reset overrides interrupts without arbitration
// - break request vectors cpu to software interrupt vector
// - in break, flag clears allowed only with break clear enable set
// - two-step clears stay blocked in break; second step after exit works
// - wait or stop clears the mask and stops cpu clock
// - wait keeps peripheral clocks; enabled interrupt wakes, stacking next cycle
// - wait ends on reset or break; break in wait sets break wait flag
// - watchdog runs through wait while watchdog disable is zero
// - stop gates base and crystal clocks; wake stacks after recovery time
// - break module inactive in stop; its registers untouched by stop
// - internal reset clears counter; pin reset does not
// - break wait flag cleared by writing zero or by reset
// - power-on or low-voltage reset holds clocks 4096 crystal cycles
module sim_ctl (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_crystal_clock_fall,
  input wire logic i_pin_reset,
  input wire logic i_internal_reset,
  input wire logic i_power_on_reset_pulse,
  input wire logic i_instr_boundary,
  input wire logic i_cpu_i_mask,
  input wire logic i_cli_exec,
  input wire logic [`NUM_IRQ-1:0] i_irq_req,
  input wire logic [`NUM_IRQ-1:0] i_irq_en,
  input wire logic i_int_serviced,
  input wire logic i_swi_exec,
  input wire logic i_rti_exec,
  input wire logic i_wait_exec,
  input wire logic i_stop_exec,
  input wire logic i_break_req,
  input wire logic [7:0] i_addr,
  input wire sim_ctl_pkg::byte_type i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output sim_ctl_pkg::byte_type o_rd_data,
  output sim_ctl_pkg::vec_type o_vector_sel,
  output logic o_stack_start,
  output logic o_stack_pc_minus1,
  output logic o_stack_high_index,
  output logic o_set_i_mask,
  output logic o_clear_i_mask,
  output logic o_restore_regs,
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_base_clock_out_en,
  output logic o_crystal_clock_en,
  output logic o_bus_clocks_en,
  output logic o_watchdog_tick,
  output logic o_watchdog_run,
  output logic o_break_active,
  output logic o_break_mode,
  output logic o_flag_clear_allow
);
  import sim_ctl_pkg::*;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [4:0] pick_irq(
    input logic [`NUM_IRQ-1:0] req,
    input logic [`NUM_IRQ-1:0] en
  );
    logic [4:0] res;
    res = 5'h00;
    for (int k = `NUM_IRQ - 1; k >= 0; k--) begin
      if (req[k] && en[k]) begin
        res = {1'b1, 4'(k)};
      end
    end
    return res;
  endfunction : pick_irq

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  sim_state_type state_r;
  logic [`CNT_WIDTH-1:0] cnt_r;
  logic [`CNT_WIDTH-1:0] rec_limit_r;
  logic latched_r;
  logic bw_r;
  logic break_clear_flag_enable_r;
  byte_type config_r;
  logic [4:0] hw_pick;
  logic any_reset;
  logic cnt_hold;
  logic cnt_last;
  logic take_hw;
  logic wake_irq;

  assign hw_pick = pick_irq(i_irq_req, i_irq_en);
  assign any_reset = i_pin_reset | i_internal_reset | i_power_on_reset_pulse;
  assign cnt_hold = i_internal_reset | i_power_on_reset_pulse | i_stop_exec |
                    (state_r == ST_STOP);
  assign cnt_last = i_crystal_clock_fall &&
                    ((state_r == ST_RECOVER && cnt_r == rec_limit_r) ||
                     (state_r == ST_STARTUP && cnt_r == `STARTUP_CYC));
  assign take_hw = i_instr_boundary && !latched_r && !i_cpu_i_mask &&
                   hw_pick[4];
  assign wake_irq = hw_pick[4];

  // ----------------------------------------------------------------
  // stabilisation counter
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
    end else if (cnt_hold) begin
      cnt_r <= '0;
    end else if (i_crystal_clock_fall) begin
      cnt_r <= cnt_r + 12'h001;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_watchdog_tick <= 1'b0;
    end else begin
      o_watchdog_tick <= !cnt_hold && i_crystal_clock_fall &&
                         (cnt_r == `CNT_ONES);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_watchdog_run <= 1'b0;
    end else begin
      o_watchdog_run <= !config_r[`BIT_WATCHDOG_DISABLE];
    end
  end

  // ----------------------------------------------------------------
  // mode sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_STARTUP;
      rec_limit_r <= `RECOVERY_LONG_CYC;
    end else if (i_power_on_reset_pulse) begin
      state_r <= ST_STARTUP;
    end else if (i_pin_reset || i_internal_reset) begin
      state_r <= ST_RUN;
    end else begin
      case (state_r)
        ST_STARTUP: begin
          if (cnt_last) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (i_stop_exec) begin
            state_r <= ST_STOP;
          end else if (i_wait_exec) begin
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (i_break_req || wake_irq) begin
            state_r <= ST_RUN;
          end
        end
        ST_STOP: begin
          if (i_break_req || wake_irq) begin
            state_r <= ST_RECOVER;
            if (config_r[`BIT_SHORT_RECOVERY]) begin
              rec_limit_r <= `RECOVERY_SHORT_CYC;
            end else begin
              rec_limit_r <= `RECOVERY_LONG_CYC;
            end
          end
        end
        ST_RECOVER: begin
          if (cnt_last) begin
            state_r <= ST_RUN;
          end
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // clock gating
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cpu_clk_en <= 1'b0;
      o_periph_clk_en <= 1'b0;
      o_bus_clocks_en <= 1'b0;
      o_base_clock_out_en <= 1'b1;
      o_crystal_clock_en <= 1'b1;
      o_break_active <= 1'b1;
    end else begin
      o_cpu_clk_en <= (state_r == ST_RUN) && !i_wait_exec &&
                      !i_stop_exec;
      o_periph_clk_en <= (state_r == ST_RUN) ||
                         (state_r == ST_WAIT);
      o_bus_clocks_en <= (state_r != ST_STARTUP);
      o_base_clock_out_en <= (state_r != ST_STOP);
      o_crystal_clock_en <= (state_r != ST_STOP);
      o_break_active <= (state_r != ST_STOP);
    end
  end

  // ----------------------------------------------------------------
  // interrupt latching and entry
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latched_r <= 1'b0;
      o_vector_sel <= '0;
      o_stack_start <= 1'b0;
      o_stack_pc_minus1 <= 1'b0;
      o_set_i_mask <= 1'b0;
    end else if (any_reset) begin
      latched_r <= 1'b0;
      o_stack_start <= 1'b0;
      o_set_i_mask <= 1'b0;
    end else begin
      o_stack_start <= 1'b0;
      o_set_i_mask <= 1'b0;
      if (i_int_serviced || i_cli_exec) begin
        latched_r <= 1'b0;
      end
      case (state_r)
        ST_RUN: begin
          if (i_instr_boundary && !latched_r && i_break_req) begin
            latched_r <= 1'b1;
            o_vector_sel <= `VEC_SWI;
            o_stack_pc_minus1 <= 1'b1;
            o_stack_start <= 1'b1;
            o_set_i_mask <= 1'b1;
          end else if (i_swi_exec && !latched_r) begin
            latched_r <= 1'b1;
            o_vector_sel <= `VEC_SWI;
            o_stack_pc_minus1 <= 1'b0;
            o_stack_start <= 1'b1;
            o_set_i_mask <= 1'b1;
          end else if (take_hw) begin
            latched_r <= 1'b1;
            o_vector_sel <= hw_pick[3:0];
            o_stack_pc_minus1 <= 1'b1;
            o_stack_start <= 1'b1;
            o_set_i_mask <= 1'b1;
          end
        end
        ST_WAIT: begin
          if (i_break_req) begin
            latched_r <= 1'b1;
            o_vector_sel <= `VEC_SWI;
            o_stack_pc_minus1 <= 1'b1;
            o_stack_start <= 1'b1;
            o_set_i_mask <= 1'b1;
          end else if (wake_irq) begin
            latched_r <= 1'b1;
            o_vector_sel <= hw_pick[3:0];
            o_stack_pc_minus1 <= 1'b1;
            o_stack_start <= 1'b1;
            o_set_i_mask <= 1'b1;
          end
        end
        ST_STOP: begin
          if (i_break_req) begin
            latched_r <= 1'b1;
            o_vector_sel <= `VEC_SWI;
            o_stack_pc_minus1 <= 1'b1;
          end else if (wake_irq) begin
            latched_r <= 1'b1;
            o_vector_sel <= hw_pick[3:0];
            o_stack_pc_minus1 <= 1'b1;
          end
        end
        ST_RECOVER: begin
          if (cnt_last) begin
            o_stack_start <= 1'b1;
            o_set_i_mask <= 1'b1;
          end
        end
        default: begin
          o_stack_start <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_stack_high_index <= 1'b0;
      o_restore_regs <= 1'b0;
      o_clear_i_mask <= 1'b0;
    end else begin
      o_stack_high_index <= 1'b0;
      o_restore_regs <= i_rti_exec && !any_reset;
      o_clear_i_mask <= (i_wait_exec || i_stop_exec) && !any_reset;
    end
  end

  // ----------------------------------------------------------------
  // break mode and flag protection
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_break_mode <= 1'b0;
    end else if (any_reset) begin
      o_break_mode <= 1'b0;
    end else if (i_break_req && (state_r == ST_WAIT ||
                 (state_r == ST_RUN && i_instr_boundary && !latched_r))) begin
      o_break_mode <= 1'b1;
    end else if (i_rti_exec) begin
      o_break_mode <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flag_clear_allow <= 1'b1;
    end else begin
      o_flag_clear_allow <= !o_break_mode || break_clear_flag_enable_r;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bw_r <= 1'b0;
    end else if (any_reset) begin
      bw_r <= 1'b0;
    end else if (state_r == ST_WAIT && i_break_req) begin
      bw_r <= 1'b1;
    end else if (i_wr && i_addr == `ADDR_BREAK_STATUS &&
                 !i_wr_data[`BIT_BREAK_WAIT]) begin
      bw_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      break_clear_flag_enable_r <= 1'b0;
      config_r <= `RST_SYS_CONFIG;
    end else if (i_wr) begin
      if (i_addr == `ADDR_BREAK_FLAG_CTRL) begin
        break_clear_flag_enable_r <= i_wr_data[`BIT_BREAK_CLEAR_ENABLE];
      end
      if (i_addr == `ADDR_SYS_CONFIG) begin
        config_r <= i_wr_data & 8'h03;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= '0;
    end else if (i_rd) begin
      case (i_addr)
        `ADDR_BREAK_STATUS: o_rd_data <= {7'h00, bw_r};
        `ADDR_BREAK_FLAG_CTRL: o_rd_data <= {7'h00, break_clear_flag_enable_r};
        `ADDR_SYS_CONFIG: o_rd_data <= config_r;
        default: o_rd_data <= 8'h00;
      endcase
    end else begin
      o_rd_data <= 8'h00;
    end
  end
endmodule : sim_ctl

/* File: sim_ctl_regs.svh */
// offsets, field positions, reset values and counts of the integration block
`ifndef SIM_CTL_REGS_SVH
`define SIM_CTL_REGS_SVH
`define ADDR_BREAK_STATUS 8'h00
`define ADDR_BREAK_FLAG_CTRL 8'h01
`define ADDR_SYS_CONFIG 8'h02
`define BIT_BREAK_WAIT 0
`define BIT_BREAK_CLEAR_ENABLE 0
`define BIT_SHORT_RECOVERY 0
`define BIT_WATCHDOG_DISABLE 1
`define RST_SYS_CONFIG 8'h00
`define NUM_IRQ 8
`define CNT_WIDTH 12
`define CNT_ONES 12'hfff
`define RECOVERY_LONG_CYC 12'hfff
`define RECOVERY_SHORT_CYC 12'h01f
`define STARTUP_CYC 12'hfff
`define VEC_SWI 4'hf
`endif

/* File: sim_ctl_pkg.sv */
// types shared by the integration block
package sim_ctl_pkg;
  typedef enum logic [2:0] {
    ST_STARTUP,
    ST_RUN,
    ST_WAIT,
    ST_STOP,
    ST_RECOVER
  } sim_state_type;
  typedef logic [7:0] byte_type;
  typedef logic [3:0] vec_type;
endpackage : sim_ctl_pkg

/* File: sim_ctl_monitor.sv */
// assertion checker for the integration block
`timescale 1ns/1ps
`include "sim_ctl_regs.svh"
module sim_ctl_monitor (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_pin_reset,
  input wire logic i_internal_reset,
  input wire logic i_power_on_reset_pulse,
  input wire logic i_instr_boundary,
  input wire logic i_cpu_i_mask,
  input wire logic [`NUM_IRQ-1:0] i_irq_req,
  input wire logic [`NUM_IRQ-1:0] i_irq_en,
  input wire logic i_swi_exec,
  input wire logic i_rti_exec,
  input wire logic i_wait_exec,
  input wire logic i_stop_exec,
  input wire logic i_break_req,
  input wire sim_ctl_pkg::vec_type o_vector_sel,
  input wire logic o_stack_start,
  input wire logic o_stack_pc_minus1,
  input wire logic o_stack_high_index,
  input wire logic o_set_i_mask,
  input wire logic o_clear_i_mask,
  input wire logic o_restore_regs,
  input wire logic o_cpu_clk_en,
  input wire logic o_periph_clk_en,
  input wire logic o_base_clock_out_en,
  input wire logic o_crystal_clock_en,
  input wire logic o_break_active,
  input wire logic o_watchdog_tick
);
  import sim_ctl_pkg::*;
  logic any_rst;
  logic run_bnd;
  logic [`NUM_IRQ-1:0] pend;
  assign any_rst = i_pin_reset | i_internal_reset | i_power_on_reset_pulse;
  assign pend = i_irq_req & i_irq_en;
  assign run_bnd = o_cpu_clk_en & i_instr_boundary & !i_break_req & !i_swi_exec;
  function automatic vec_type pick(input logic [`NUM_IRQ-1:0] p);
    pick = 4'h0;
    for (int k = `NUM_IRQ - 1; k >= 0; k--) begin
      if (p[k]) pick = vec_type'(k);
    end
  endfunction : pick
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n || any_rst);
  a_mask_with_stack: assert property (
    o_stack_start == o_set_i_mask) else $error("mask set apart from stacking");
  a_no_high_index: assert property (
    !o_stack_high_index) else $error("high index stacked");
  a_masked_refused: assert property (
    run_bnd && i_cpu_i_mask |=> !o_stack_start)
    else $error("masked interrupt taken");
  a_hw_priority: assert property (
    run_bnd && !i_cpu_i_mask && pend != '0
    |=> !o_stack_start || o_vector_sel == pick($past(pend)))
    else $error("wrong priority");
  a_swi_vector: assert property (
    o_stack_start && !o_stack_pc_minus1 |-> o_vector_sel == `VEC_SWI)
    else $error("software entry with wrong vector");
  a_break_entry: assert property (
    o_cpu_clk_en && i_break_req && i_instr_boundary
    |=> o_stack_start && o_vector_sel == `VEC_SWI)
    else $error("break not vectored");
  a_low_power_mask: assert property (
    o_cpu_clk_en && (i_wait_exec || i_stop_exec) |=> o_clear_i_mask)
    else $error("mask not cleared");
  a_rti_restore: assert property (
    o_cpu_clk_en && i_rti_exec |=> o_restore_regs)
    else $error("no restore after return");
  a_stop_gates: assert property (
    o_cpu_clk_en && i_stop_exec |-> ##[1:2]
    (!o_base_clock_out_en && !o_crystal_clock_en && !o_break_active))
    else $error("stop left clocks running");
  a_wait_clocks: assert property (
    o_cpu_clk_en && i_wait_exec |-> ##[1:2] (!o_cpu_clk_en && o_periph_clk_en))
    else $error("wait clocks wrong");
  a_tick_single: assert property (
    o_watchdog_tick |=> !o_watchdog_tick [*8]) else $error("tick repeated");
endmodule : sim_ctl_monitor
bind sim_ctl sim_ctl_monitor mon_u (.i_clk_sys, .i_rst_n, .i_pin_reset,
  .i_internal_reset, .i_power_on_reset_pulse, .i_instr_boundary,
  .i_cpu_i_mask, .i_irq_req, .i_irq_en, .i_swi_exec, .i_rti_exec,
  .i_wait_exec, .i_stop_exec, .i_break_req, .o_vector_sel, .o_stack_start,
  .o_stack_pc_minus1, .o_stack_high_index, .o_set_i_mask, .o_clear_i_mask,
  .o_restore_regs, .o_cpu_clk_en, .o_periph_clk_en, .o_base_clock_out_en,
  .o_crystal_clock_en, .o_break_active, .o_watchdog_tick);

/* File: sim_ctl_cpu_model.sv */
// cpu core model facing the integration block
`timescale 1ns/1ps
module sim_ctl_cpu_model (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_slow,
  input wire logic i_sei,
  input wire logic i_cli,
  input wire logic i_stack_start,
  input wire logic i_set_mask,
  input wire logic i_clr_mask,
  input wire logic i_restore,
  output logic o_mask,
  output logic o_serviced
);
  logic [3:0] wait_r;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mask <= 1'h1;
    end else if (i_set_mask || i_sei) begin
      o_mask <= 1'h1;
    end else if (i_clr_mask || i_cli || i_restore) begin
      o_mask <= 1'h0;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_r <= 4'h0;
      o_serviced <= 1'h0;
    end else begin
      o_serviced <= (wait_r == 4'h1);
      if (i_stack_start) begin
        wait_r <= i_slow ? 4'hc : 4'h2;
      end else if (wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end
    end
  end
endmodule : sim_ctl_cpu_model

/* File: sim_ctl_tb.sv */
// self-checking testbench of the integration block
`timescale 1ns/1ps
`include "sim_ctl_regs.svh"
module sim_ctl_tb;
  import sim_ctl_pkg::*;
  localparam logic [7:0] BND = 8'h40, SOFTWARE_INTERRUPT_INSTR = 8'h20, RETURN_FROM_INTERRUPT_INSTR = 8'h10, WT = 8'h08;
  localparam logic [7:0] SP = 8'h04, BRK = 8'h02, CLI = 8'h01, SEI = 8'h80;
  logic i_clk_sys = 1'h0;
  logic i_rst_n = 1'h0;
  logic i_pin_reset = 1'h0;
  logic slow = 1'h0;
  logic xfall = 1'h1;
  logic irst = 1'h0;
  logic por = 1'h0;
  logic [7:0] evt = 8'h00;
  logic [7:0] i_addr = 8'h00;
  byte_type i_wr_data = 8'h00;
  logic i_wr = 1'h0;
  logic i_rd = 1'h0;
  logic [`NUM_IRQ-1:0] i_irq_req = '0;
  logic [`NUM_IRQ-1:0] i_irq_en = '0;
  logic mask, serviced;
  byte_type o_rd_data;
  vec_type o_vector_sel;
  logic o_stack_start, o_stack_pc_minus1, o_stack_high_index, o_set_i_mask;
  logic o_clear_i_mask, o_restore_regs, o_cpu_clk_en, o_periph_clk_en;
  logic o_base_clock_out_en, o_crystal_clock_en, o_bus_clocks_en;
  logic o_watchdog_tick, o_watchdog_run, o_break_active, o_break_mode;
  logic o_flag_clear_allow;
  int error_cnt = 0;
  int n_compared = 0;
  int n;
  always #20 i_clk_sys = ~i_clk_sys;
  sim_ctl dut_u (.i_clk_sys, .i_rst_n, .i_crystal_clock_fall(xfall),
    .i_pin_reset, .i_internal_reset(irst), .i_power_on_reset_pulse(por),
    .i_instr_boundary(evt[6]), .i_cpu_i_mask(mask), .i_cli_exec(evt[0]),
    .i_irq_req, .i_irq_en, .i_int_serviced(serviced), .i_swi_exec(evt[5]),
    .i_rti_exec(evt[4]), .i_wait_exec(evt[3]), .i_stop_exec(evt[2]),
    .i_break_req(evt[1]), .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data,
    .o_vector_sel, .o_stack_start, .o_stack_pc_minus1, .o_stack_high_index,
    .o_set_i_mask, .o_clear_i_mask, .o_restore_regs, .o_cpu_clk_en,
    .o_periph_clk_en, .o_base_clock_out_en, .o_crystal_clock_en,
    .o_bus_clocks_en, .o_watchdog_tick, .o_watchdog_run, .o_break_active,
    .o_break_mode, .o_flag_clear_allow);
  sim_ctl_cpu_model cpu_u (.i_clk_sys, .i_rst_n, .i_slow(slow),
    .i_sei(evt[7]), .i_cli(evt[0]), .i_stack_start(o_stack_start),
    .i_set_mask(o_set_i_mask), .i_clr_mask(o_clear_i_mask),
    .i_restore(o_restore_regs), .o_mask(mask), .o_serviced(serviced));
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int c);
    repeat (c) @(posedge i_clk_sys);
    #1;
  endtask : cyc
  task automatic fire(input logic [7:0] e);
    @(posedge i_clk_sys);
    evt <= e;
    @(posedge i_clk_sys);
    evt <= 8'h00;
    #1;
  endtask : fire
  task automatic setq(input logic [7:0] e, input logic [7:0] r, input logic p);
    @(posedge i_clk_sys);
    i_irq_en <= e;
    i_irq_req <= r;
    i_pin_reset <= p;
  endtask : setq
  task automatic wr(input logic [7:0] a, input byte_type d);
    @(posedge i_clk_sys);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input byte_type exp);
    @(posedge i_clk_sys);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'h0;
    #1;
    chk(o_rd_data, exp);
  endtask : rd
  task automatic wt(input logic [1:0] sel, input int lim);
    n = 0;
    while ((sel == 2'h2 ? o_watchdog_tick :
            sel[0] ? o_stack_start : o_bus_clocks_en) !== 1'h1) begin
      if (n == lim) begin
        error_cnt++;
        close_out();
      end
      cyc(1);
      n++;
    end
  endtask : wt
  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_rst_n <= 1'h1;
    wt(2'h0, 5000);
    chk(8'(n >= 4090 && n <= 4100), 8'h01);
    rd(`ADDR_SYS_CONFIG, `RST_SYS_CONFIG);
    rd(8'h10, 8'h00);
    wr(`ADDR_SYS_CONFIG, 8'h1 << `BIT_WATCHDOG_DISABLE);
    cyc(2);
    chk(8'(o_watchdog_run), 8'h00);
    wr(`ADDR_SYS_CONFIG, 8'h1 << `BIT_SHORT_RECOVERY);
    rd(`ADDR_SYS_CONFIG, 8'h01);
    n = 0;
    repeat (8192) begin
      cyc(1);
      n += int'(o_watchdog_tick === 1'h1);
    end
    chk(8'(n), 8'h02);
    @(posedge i_clk_sys);
    xfall <= 1'h0;
    n = 0;
    repeat (4200) begin
      cyc(1);
      n += int'(o_watchdog_tick === 1'h1);
    end
    chk(8'(n), 8'h00);
    @(posedge i_clk_sys);
    xfall <= 1'h1;
    $display("test counter done");
    fire(CLI);
    setq(8'hfd, 8'h26, 1'h0);
    fire(BND);
    chk(8'(o_stack_start), 8'h01);
    chk(8'(o_vector_sel), 8'h02);
    chk(8'(o_set_i_mask), 8'h01);
    chk(8'(o_stack_pc_minus1), 8'h01);
    chk(8'(o_stack_high_index), 8'h00);
    cyc(6);
    fire(BND);
    chk(8'(o_stack_start), 8'h00);
    setq(8'hfd, 8'h22, 1'h0);
    fire(RETURN_FROM_INTERRUPT_INSTR);
    chk(8'(o_restore_regs), 8'h01);
    fire(BND);
    chk(8'(o_stack_start), 8'h01);
    chk(8'(o_vector_sel), 8'h05);
    setq(8'hff, 8'h00, 1'h0);
    cyc(6);
    fire(RETURN_FROM_INTERRUPT_INSTR);
    fire(SEI);
    fire(SOFTWARE_INTERRUPT_INSTR | BND);
    chk(8'(o_vector_sel), 8'(`VEC_SWI));
    chk(8'(o_stack_pc_minus1), 8'h00);
    cyc(6);
    fire(RETURN_FROM_INTERRUPT_INSTR);
    $display("test interrupt done");
    fire(BRK | BND);
    chk(8'(o_vector_sel), 8'(`VEC_SWI));
    cyc(1);
    chk(8'(o_break_mode), 8'h01);
    chk(8'(o_flag_clear_allow), 8'h00);
    wr(`ADDR_BREAK_FLAG_CTRL, 8'h01);
    cyc(1);
    chk(8'(o_flag_clear_allow), 8'h01);
    wr(`ADDR_BREAK_FLAG_CTRL, 8'h00);
    cyc(4);
    fire(RETURN_FROM_INTERRUPT_INSTR);
    cyc(1);
    chk(8'(o_break_mode), 8'h00);
    $display("test break done");
    @(posedge i_clk_sys);
    slow <= 1'h1;
    fire(WT);
    chk(8'(o_clear_i_mask), 8'h01);
    cyc(1);
    chk(8'(o_cpu_clk_en), 8'h00);
    chk(8'(o_periph_clk_en), 8'h01);
    chk(8'(o_watchdog_run), 8'h01);
    fire(BRK);
    cyc(14);
    fire(RETURN_FROM_INTERRUPT_INSTR);
    rd(`ADDR_BREAK_STATUS, 8'h01);
    wr(`ADDR_BREAK_STATUS, 8'h00);
    rd(`ADDR_BREAK_STATUS, 8'h00);
    fire(WT);
    setq(8'hff, 8'h08, 1'h0);
    wt(2'h1, 20);
    chk(8'(n <= 2), 8'h01);
    chk(8'(o_vector_sel), 8'h03);
    setq(8'hff, 8'h00, 1'h0);
    cyc(14);
    fire(RETURN_FROM_INTERRUPT_INSTR);
    $display("test wait done");
    fire(SP);
    cyc(2);
    chk(8'(o_base_clock_out_en), 8'h00);
    chk(8'(o_crystal_clock_en), 8'h00);
    chk(8'(o_break_active), 8'h00);
    setq(8'hff, 8'h02, 1'h0);
    wt(2'h1, 200);
    chk(8'(n >= 30 && n <= 36), 8'h01);
    chk(8'(o_vector_sel), 8'h01);
    cyc(16);
    setq(8'hff, 8'h01, 1'h1);
    fire(BRK | BND);
    chk(8'(o_stack_start), 8'h00);
    chk(8'(o_break_mode), 8'h00);
    setq(8'hff, 8'h00, 1'h0);
    $display("test stop done");
    wt(2'h2, 4200);
    cyc(100);
    @(posedge i_clk_sys);
    i_pin_reset <= 1'h1;
    @(posedge i_clk_sys);
    i_pin_reset <= 1'h0;
    cyc(1);
    wt(2'h2, 4200);
    chk(8'(n >= 3985 && n <= 4000), 8'h01);
    @(posedge i_clk_sys);
    irst <= 1'h1;
    @(posedge i_clk_sys);
    irst <= 1'h0;
    cyc(1);
    wt(2'h2, 4200);
    chk(8'(n >= 4090 && n <= 4100), 8'h01);
    @(posedge i_clk_sys);
    por <= 1'h1;
    @(posedge i_clk_sys);
    por <= 1'h0;
    cyc(2);
    chk(8'(o_bus_clocks_en), 8'h00);
    wt(2'h0, 4200);
    chk(8'(n >= 4090 && n <= 4100), 8'h01);
    $display("test reset done");
    close_out();
  end
endmodule : sim_ctl_tb
